// ===== core/ema_host.sv
`timescale 1ns/1ps
`include "ema_cfg.svh"
module ema_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire ema_pkg::ema_apb_req_type apb_req,
	output ema_pkg::ema_apb_rsp_type apb_rsp,
	output ema_pkg::ema_spi_type spi_out,
	input wire logic spi_miso
);
	import ema_pkg::*;

	// ==========================================================
	// Constants and helpers
	localparam int HALF_CYC = `EMA_SCLK_HALF_NS / `EMA_CLK_NS;
	localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);

	// Frame: write flag, 7-bit byte address, 16-bit data
	function automatic logic [23:0] frame_word(input logic wr, input logic [6:0] adr,
		input logic [15:0] dat);
		return {wr, adr, dat};
	endfunction

	function automatic logic [15:0] action_code_field_word(input logic [1:0] code);
		if (code == 2'b00) begin
			return 16'h0000;
		end
		return {2'b00, code, 4'h0, `EMA_UNLOCK_CODE};
	endfunction

	function automatic logic apb_mapped(input logic [7:0] adr);
		return adr == `EMA_R_CMD || adr == `EMA_R_ADDR || adr == `EMA_R_WDATA ||
			adr == `EMA_R_RDATA || adr == `EMA_R_STATUS || adr == `EMA_R_FLAGS;
	endfunction

	ema_state_type s_r;
	ema_state_type s_nxt;
	logic tick;
	logic fr_start;
	logic fr_end;
	logic rd;
	logic ecc;
	logic wr_acc;
	logic [15:0] resp;
	logic [6:0] cs_adr;
	logic [23:0] tx_word;
	logic [2:0] op_field;

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		fr_end = 1'b0;
		resp = s_r.rx[15:0];
		rd = s_r.op == OP_READ;
		cs_adr = rd ? `EMA_A_RD_CS : `EMA_A_WR_CS;
		tick = (s_r.fr_act || s_r.fr_gap) && s_r.div == HALF_LAST;
		ecc = s_r.warn[`EMA_WARN_ECC1] | s_r.err[`EMA_ERR_ECC2];
		wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
		op_field = apb_req.pwdata[2:0];

		// Miso crosses in from the pin
		s_nxt.miso_m = spi_miso;
		s_nxt.miso_s = s_r.miso_m;

		// Word for the frame of the current step
		unique case (s_r.seq)
			S_IDLE, S_END: begin
				tx_word = 24'h000000;
			end
			S_CTRL: begin
				if (s_r.op == OP_CLEAR) begin
					tx_word = frame_word(1'b1, `EMA_A_CONTROL, `EMA_CLEAR_WORD); // [R1]
				end else begin
					tx_word = frame_word(1'b1, `EMA_A_CONTROL, action_code_field_word(s_r.code)); // [R3] [R4]
				end
			end
			S_ADDR: begin
				tx_word = frame_word(1'b1, rd ? `EMA_A_RD_ADR : `EMA_A_WR_ADR, {8'h00, s_r.tgt}); // [R8]
			end
			S_WDH: begin
				tx_word = frame_word(1'b1, `EMA_A_WR_HI, s_r.wdata[31:16]); // [R21]
			end
			S_WDL: begin
				tx_word = frame_word(1'b1, `EMA_A_WR_LO, s_r.wdata[15:0]);
			end
			S_TRIG: begin
				tx_word = frame_word(1'b1, cs_adr, `EMA_TRIG_WORD); // [R10] [R9] [R19]
			end
			S_POLL: begin
				tx_word = frame_word(1'b0, cs_adr, 16'h0000); // [R11]
			end
			S_RDH: begin
				tx_word = frame_word(1'b0, `EMA_A_RD_HI, 16'h0000); // [R16]
			end
			S_RDL: begin
				tx_word = frame_word(1'b0, `EMA_A_RD_LO, 16'h0000);
			end
			S_WARN: begin
				tx_word = frame_word(1'b0, `EMA_A_WARN, 16'h0000);
			end
			S_ERR: begin
				tx_word = frame_word(1'b0, `EMA_A_ERR, 16'h0000);
			end
			S_NOP: begin
				tx_word = frame_word(1'b0, `EMA_A_ANGLE, 16'h0000);
			end
		endcase
		fr_start = s_r.seq != S_IDLE && s_r.seq != S_END && !s_r.fr_act && !s_r.fr_gap;

		// Frame engine, clock idles low, data changes on the falling edge
		if (fr_start) begin
			s_nxt.fr_act = 1'b1;
			s_nxt.tx = tx_word;
			s_nxt.half = 6'd0;
			s_nxt.div = 3'h0;
			s_nxt.spi.cs_n = 1'b0;
			s_nxt.spi.mosi = tx_word[23];
		end else if (s_r.fr_act || s_r.fr_gap) begin
			s_nxt.div = tick ? 3'h0 : s_r.div + 3'h1;
			if (tick && s_r.fr_gap) begin
				s_nxt.fr_gap = 1'b0;
			end else if (tick) begin
				if (!s_r.half[0]) begin
					s_nxt.spi.sclk = 1'b1;
					s_nxt.rx = {s_r.rx[22:0], s_r.miso_s};
				end else begin
					s_nxt.spi.sclk = 1'b0;
					if (s_r.half == `EMA_FRAME_HALVES) begin
						s_nxt.fr_act = 1'b0;
						s_nxt.fr_gap = 1'b1;
						s_nxt.spi.cs_n = 1'b1;
						s_nxt.spi.mosi = 1'b0;
						fr_end = 1'b1;
					end else begin
						s_nxt.tx = {s_r.tx[22:0], 1'b0};
						s_nxt.spi.mosi = s_r.tx[22];
					end
				end
				s_nxt.half = s_r.half + 6'd1;
			end
		end

		// Each frame returns the answer to the one before it
		if (fr_end) begin
			unique case (s_r.seq)
				S_IDLE, S_END: begin
				end
				S_CTRL: begin
					s_nxt.seq = rd ? S_ADDR : S_END;
				end
				S_ADDR: begin
					s_nxt.seq = rd ? S_TRIG : S_WDH;
				end
				S_WDH: begin
					s_nxt.seq = S_WDL;
				end
				S_WDL: begin
					s_nxt.seq = S_TRIG;
				end
				S_TRIG: begin
					s_nxt.seq = S_POLL;
					s_nxt.primed = 1'b0;
				end
				S_POLL: begin
					// First answer belongs to the trigger frame; no timeout, device bounds it
					if (s_r.primed && resp[`EMA_DONE_BIT]) begin // [R11] [R14]
						s_nxt.seq = rd ? S_RDH : S_WARN;
					end
					s_nxt.primed = 1'b1;
				end
				S_RDH: begin
					s_nxt.seq = S_RDL; // [R16]
				end
				S_RDL: begin
					s_nxt.rdata[31:16] = resp; // [R20]
					s_nxt.seq = S_WARN;
				end
				S_WARN: begin
					if (rd) begin
						s_nxt.rdata[15:0] = resp;
					end
					s_nxt.seq = S_ERR;
				end
				S_ERR: begin
					s_nxt.warn = resp;
					s_nxt.seq = S_NOP;
				end
				S_NOP: begin
					s_nxt.err = resp;
					s_nxt.seq = S_END;
				end
			endcase
		end

		// ==========================================================
		// Register bus
		s_nxt.prd = 32'h00000000;
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			unique case (apb_req.paddr)
				`EMA_R_ADDR: s_nxt.prd = {24'h000000, s_r.ext_adr};
				`EMA_R_WDATA: s_nxt.prd = s_r.wdata;
				`EMA_R_RDATA: s_nxt.prd = s_r.rdata;
				`EMA_R_STATUS: s_nxt.prd = {27'h0000000, s_r.suspect, s_r.fmt_err, s_r.fail,
					s_r.done, s_r.seq != S_IDLE};
				`EMA_R_FLAGS: s_nxt.prd = {s_r.err, s_r.warn};
				default: s_nxt.prd = 32'h00000000;
			endcase
		end
		if (wr_acc) begin
			unique case (apb_req.paddr)
				`EMA_R_ADDR: s_nxt.ext_adr = apb_req.pwdata[7:0];
				`EMA_R_WDATA: s_nxt.wdata = apb_req.pwdata;
				`EMA_R_STATUS: begin
					if (apb_req.pwdata[`EMA_ST_DONE]) begin
						s_nxt.done = 1'b0;
					end
				end
				`EMA_R_CMD: begin
					// Commands while busy are dropped
					if (s_r.seq == S_IDLE && apb_req.pwdata[`EMA_CMD_GO] &&
						op_field >= `EMA_CMD_OP_READ && op_field <= `EMA_CMD_OP_ACTION_CODE_FIELD) begin
						s_nxt.op = ema_op_type'(2'(op_field - `EMA_CMD_OP_READ));
						s_nxt.code = apb_req.pwdata[5:4];
						s_nxt.tgt = apb_req.pwdata[`EMA_CMD_SHADOW] ?
							s_r.ext_adr + `EMA_SHADOW_OFS : s_r.ext_adr; // [R18] [R19]
						s_nxt.done = 1'b0;
						s_nxt.fail = 1'b0;
						s_nxt.fmt_err = 1'b0;
						s_nxt.suspect = 1'b0;
						s_nxt.seq = (op_field == `EMA_CMD_OP_READ &&
							apb_req.pwdata[5:4] == 2'b00) ||
							op_field == `EMA_CMD_OP_WRITE ? S_ADDR : S_CTRL;
					end
				end
				default: begin
				end
			endcase
		end

		// ==========================================================
		// Verdicts; a finishing step wins over a done clear in the same cycle
		if (s_r.seq == S_END) begin
			s_nxt.done = 1'b1;
			s_nxt.fmt_err = rd && s_r.rdata[`EMA_PAD_MSB:`EMA_PAD_LSB] != 2'b00; // [R17]
			s_nxt.suspect = s_r.op == OP_WRITE && (ecc || s_r.warn[`EMA_WARN_XACC] ||
				s_r.warn[`EMA_WARN_IFACE] || s_r.warn[`EMA_WARN_CRC] ||
				s_r.warn[`EMA_WARN_BUSY]); // [R2]
			s_nxt.fail = rd && s_r.code != 2'b00 && (ecc ||
				s_r.rdata[`EMA_DATA_MSB:0] != s_r.wdata[`EMA_DATA_MSB:0]); // [R5] [R6]
			s_nxt.seq = S_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.spi.cs_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign spi_out = s_r.spi;
	assign apb_rsp.prdata = s_r.prd;
	assign apb_rsp.pready = apb_req.psel && apb_req.penable;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !apb_mapped(apb_req.paddr);

	// ==========================================================
	// Checks
	a_clear_word: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(s_r.seq == S_CTRL && s_r.op == OP_CLEAR && fr_start) |=>
		(s_r.tx[15:0] == `EMA_CLEAR_WORD && s_r.tx[22:16] == `EMA_A_CONTROL))
		else $error("clear word wrong");

	a_low_margin: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(s_r.seq == S_CTRL && s_r.op == OP_READ && s_r.code == 2'b01 && fr_start) |=>
		(s_r.tx[15:12] == 4'h1 && s_r.tx[7:0] == `EMA_UNLOCK_CODE))
		else $error("low margin code wrong");

	a_high_margin: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		(s_r.seq == S_CTRL && s_r.op == OP_READ && s_r.code == 2'b10 && fr_start) |=>
		(s_r.tx[15:12] == 4'h2 && s_r.tx[23:16] == {1'b1, `EMA_A_CONTROL}))
		else $error("high margin code wrong");

	a_addr_load: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(s_r.seq == S_ADDR && rd && fr_start) |=>
		(s_r.tx[23:16] == {1'b1, `EMA_A_RD_ADR} && s_r.tx[15:0] == {8'h00, s_r.tgt}))
		else $error("read address load wrong");

	a_trig_byte: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		(s_r.seq == S_TRIG && fr_start) |=> (s_r.tx[15:0] == `EMA_TRIG_WORD && s_r.fr_act))
		else $error("trigger word wrong");

	a_poll_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		(s_r.seq == S_POLL && fr_end && !(s_r.primed && resp[`EMA_DONE_BIT])) |=>
		(s_r.seq == S_POLL))
		else $error("data fetched before done");

	a_hi_then_lo: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(s_r.seq == S_RDH && fr_end) |=> (s_r.seq == S_RDL && !s_r.fr_act))
		else $error("halves out of order");

	a_pipe_resp: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		(s_r.seq == S_RDL && fr_end) |=> (s_r.rdata[31:16] == $past(s_r.rx[15:0])))
		else $error("upper half not taken");

	a_margin_fail: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(s_r.seq == S_END && rd && s_r.code != 2'b00 && s_r.warn[`EMA_WARN_ECC1]) |=>
		(s_r.fail && s_r.done))
		else $error("margin failure missed");

	a_write_suspect: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		(s_r.seq == S_END && s_r.op == OP_WRITE && s_r.warn[`EMA_WARN_BUSY]) |=>
		(s_r.suspect && s_r.seq == S_IDLE))
		else $error("suspect write missed");

	a_rdh_word: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(s_r.seq == S_RDH && fr_start) |=> (s_r.tx[23:16] == {1'b0, `EMA_A_RD_HI}))
		else $error("upper half read word wrong");

	a_rdl_word: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(s_r.seq == S_RDL && fr_start) |=> (s_r.tx[23:16] == {1'b0, `EMA_A_RD_LO}))
		else $error("lower half read word wrong");

	a_poll_word: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(s_r.seq == S_POLL && fr_start) |=> (s_r.tx[23:16] == {1'b0, cs_adr}))
		else $error("poll word wrong");

	a_done_exit: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(s_r.seq == S_POLL && fr_end && s_r.primed && resp[`EMA_DONE_BIT]) |=>
		(s_r.seq == (rd ? S_RDH : S_WARN)))
		else $error("poll did not end on done");

	a_low_data: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		(s_r.seq == S_WARN && fr_end && rd) |=> (s_r.rdata[15:0] == $past(s_r.rx[15:0])))
		else $error("lower half not taken");

	a_clear_end: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(s_r.seq == S_CTRL && s_r.op == OP_CLEAR && fr_end) |=> (s_r.seq == S_END))
		else $error("clear did not finish");

	a_fail_data: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(s_r.seq == S_END && rd && s_r.code != 2'b00 &&
		s_r.rdata[`EMA_DATA_MSB:0] != s_r.wdata[`EMA_DATA_MSB:0]) |=> (s_r.fail))
		else $error("margin data mismatch missed");

	a_margin_first: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(wr_acc && apb_req.paddr == `EMA_R_CMD && s_r.seq == S_IDLE &&
		apb_req.pwdata[`EMA_CMD_GO] && op_field == `EMA_CMD_OP_READ &&
		apb_req.pwdata[5:4] != 2'b00) |=> (s_r.seq == S_CTRL))
		else $error("margin read skipped control");

endmodule // ema_host

// ===== core/ema_cfg.svh
`ifndef EMA_CFG_SVH
`define EMA_CFG_SVH
// Summary of operation
// [R1] Before margining, clear error and warning registers via the clear bits of control.
// [R2] After a write, check ECC, access, interface, CRC and busy flags; retry if set. The host only sets suspect and does not retry.
// [R3] Action code 0001b reads EEPROM at a lowered threshold; host rereads and verifies.
// [R4] Action code 0010b reads at a raised threshold; host verifies data and ECC flags.
// [R5] Margining fails on any data mismatch or either ECC flag set.
// [R6] After a margin failure write and check once more; reject part if it persists. The host only sets fail and does not rewrite.
// [R7] Every extended location, EEPROM or shadow, is reachable as one word up to 32 bits.
// [R8] Host loads the 8-bit target into the extended read address register first.
// [R9] Writing 1 to the read trigger starts a read that fills both read-data registers.
// [R10] Host starts the read by writing 0x80 to the trigger's upper byte.
// [R11] Read completion shows in bit 0 of the lower byte; host polls it first.
// [R12] An EEPROM extended read completes within 2 microseconds.
// [R13] A shadow read completes one system clock after the trigger is synchronised.
// [R14] Host never reads the read-data registers while a read may be running.
// [R15] Read data changing during a serial read may raise an interface CRC error.
// [R16] Host fetches the 32-bit result in two packets, upper half before lower half.
// [R17] EEPROM words carry CRC in [31:26], zero in [25:24], data in [23:0].
// [R18] Shadow locations sit at the EEPROM location plus 0x40.
// [R19] Shadow accesses use the same registers, triggers and flags as EEPROM accesses.
// [R20] Frames pipeline: a new command goes out while the previous answer returns.
// [R21] Write trigger copies both write-data halves to the write address location.
// [R22] EEPROM write ends within 24 ms with write-done set; shadow write in one clock.
// [R23] A locked location ends the access, sets its done flag and the access warning.
// [R24] Read trigger sets read-in-progress, clears read-done, and always reads back 0.
// [R25] Read data hold until the next read completes; in-progress clears with done.

// ==========================================================
// Device register byte addresses
`define EMA_A_WR_ADR 7'h02
`define EMA_A_WR_HI 7'h04
`define EMA_A_WR_LO 7'h06
`define EMA_A_WR_CS 7'h08
`define EMA_A_RD_ADR 7'h0A
`define EMA_A_RD_CS 7'h0C
`define EMA_A_RD_HI 7'h0E
`define EMA_A_RD_LO 7'h10
`define EMA_A_CONTROL 7'h1E
`define EMA_A_ANGLE 7'h20
`define EMA_A_ERR 7'h24
`define EMA_A_WARN 7'h26

// ==========================================================
// Device field values and positions
`define EMA_TRIG_WORD 16'h8000
`define EMA_CLEAR_WORD 16'h0300
`define EMA_UNLOCK_CODE 8'hA5
`define EMA_DONE_BIT 0
`define EMA_SHADOW_OFS 8'h40
`define EMA_DATA_MSB 23
`define EMA_PAD_MSB 25
`define EMA_PAD_LSB 24
`define EMA_WARN_IFACE 11
`define EMA_WARN_CRC 10
`define EMA_WARN_XACC 7
`define EMA_WARN_ECC1 5
`define EMA_WARN_BUSY 2
`define EMA_ERR_ECC2 5

// ==========================================================
// Host register byte offsets and fields
`define EMA_R_CMD 8'h00
`define EMA_R_ADDR 8'h04
`define EMA_R_WDATA 8'h08
`define EMA_R_RDATA 8'h0C
`define EMA_R_STATUS 8'h10
`define EMA_R_FLAGS 8'h14
`define EMA_CMD_GO 31
`define EMA_CMD_SHADOW 8
`define EMA_CMD_OP_READ 3'h1
`define EMA_CMD_OP_WRITE 3'h2
`define EMA_CMD_OP_CLEAR 3'h3
`define EMA_CMD_OP_ACTION_CODE_FIELD 3'h4
`define EMA_ST_DONE 1

// ==========================================================
// Timing
`define EMA_CLK_NS 100
`define EMA_SCLK_HALF_NS 400
`define EMA_FRAME_HALVES 6'd47

`endif

// ===== core/ema_pkg.sv
package ema_pkg;

	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_CLEAR, OP_ACTION_CODE_FIELD} ema_op_type;

	typedef enum logic [3:0] {S_IDLE, S_CTRL, S_ADDR, S_WDH, S_WDL, S_TRIG, S_POLL,
		S_RDH, S_RDL, S_WARN, S_ERR, S_NOP, S_END} ema_seq_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ema_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ema_apb_rsp_type;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} ema_spi_type;

	typedef struct packed {
		ema_seq_type seq;
		ema_op_type op;
		logic [1:0] code;
		logic [7:0] ext_adr;
		logic [7:0] tgt;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [15:0] warn;
		logic [15:0] err;
		logic done;
		logic fail;
		logic fmt_err;
		logic suspect;
		logic primed;
		logic [31:0] prd;
		logic fr_act;
		logic fr_gap;
		logic [5:0] half;
		logic [2:0] div;
		logic [23:0] tx;
		logic [23:0] rx;
		logic miso_m;
		logic miso_s;
		ema_spi_type spi;
	} ema_state_type;

endpackage

// ===== verif/ema_dev_model.sv
`timescale 1ns/1ps
// ==========================================================
// Device side of the serial link: extended access registers
module ema_dev_model #(
	parameter int EE_RD_NS = 1500,
	parameter int EE_WR_NS = 50000,
	parameter logic [7:0] WEAK_ADR = 8'h05,
	parameter logic [7:0] LOCK_ADR = 8'h3F
) (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso
);
	logic [31:0] mem [0:255];
	logic [31:0] w;
	logic [23:0] rx, tx;
	logic [15:0] wr_hi, wr_lo, rd_hi, rd_lo, warn, resp;
	logic [7:0] wr_adr, rd_adr;
	logic [3:0] action_code;
	logic rd_done, rd_busy, wr_done, wr_busy;
	event rd_go, wr_go;

	initial begin
		{rd_done, rd_busy, wr_done, wr_busy, warn, action_code, resp, miso} = '0;
		{wr_adr, rd_adr, wr_hi, wr_lo, rd_hi, rd_lo, rx} = '0;
		for (int i = 0; i < 256; i++) mem[i] = {24'h58A456, 8'(i)};
	end

	function automatic logic [15:0] reg_rd(input logic [6:0] a);
		case (a)
			7'h08: return {7'h00, wr_busy, 7'h00, wr_done};
			7'h0C: return {7'h00, rd_busy, 7'h00, rd_done};
			7'h0E: return rd_hi;
			7'h10: return rd_lo;
			7'h1E: return {action_code, 12'h000};
			7'h26: return warn;
			default: return 16'h0000;
		endcase
	endfunction

	// ==========================================================
	// Frame shifting: answer of a read leaves in the next frame
	always @(posedge sclk) rx <= {rx[22:0], mosi};
	always @(negedge cs_n) begin
		tx = {8'h00, resp};
		miso = tx[23];
	end
	always @(negedge sclk) if (!cs_n) begin
		tx = {tx[22:0], 1'b0};
		miso = tx[23];
	end
	// Released line flips so a stale bit never passes for data
	always @(posedge cs_n) begin
		miso = ~miso;
		resp = reg_rd(rx[22:16]);
		// Data fetched mid-read is flagged as an interface CRC warning (bit 10)
		if (rx[23] === 1'b0 && rd_busy && (rx[22:16] == 7'h0E || rx[22:16] == 7'h10)) begin
			warn[10] = 1'b1;
		end
		if (rx[23] === 1'b1) begin
			case (rx[22:16])
				7'h02: wr_adr = rx[7:0];
				7'h04: wr_hi = rx[15:0];
				7'h06: wr_lo = rx[15:0];
				7'h0A: rd_adr = rx[7:0];
				7'h1E: begin
					action_code = rx[15:12];
					if (rx[9]) warn = '0;
				end
				7'h08: if (rx[15]) begin
					{wr_busy, wr_done} = 2'b10;
					-> wr_go;
				end
				7'h0C: if (rx[15]) begin
					{rd_busy, rd_done} = 2'b10;
					-> rd_go;
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Access engines: shadow answers after 100 ns, EEPROM slowly
	always @(rd_go) begin
		#(rd_adr >= 8'h40 ? 100 : EE_RD_NS);
		w = mem[rd_adr];
		if (rd_adr == WEAK_ADR && action_code == 4'h1) w[0] = ~w[0];
		{rd_hi, rd_lo} = w;
		{rd_busy, rd_done} = 2'b01;
	end
	always @(wr_go) begin
		if (wr_adr == LOCK_ADR) begin
			warn[7] = 1'b1;
		end else begin
			#(wr_adr >= 8'h40 ? 100 : EE_WR_NS);
			mem[wr_adr] = {wr_hi, wr_lo};
		end
		{wr_busy, wr_done} = 2'b01;
	end
endmodule // ema_dev_model

// ===== verif/ema_host_tb.sv
`timescale 1ns/1ps
`include "ema_cfg.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin error_cnt++; \
	$display("BAD %0t got %0h exp %0h", $time, g, x); end end
module ema_host_tb;
	import ema_pkg::*;
	logic pclk, presetn, miso;
	ema_apb_req_type req;
	ema_apb_rsp_type rsp;
	ema_spi_type spi;
	int error_cnt, cmp_count;

	ema_host u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.spi_out(spi), .spi_miso(miso));
	ema_dev_model u_dev (.sclk(spi.sclk), .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(miso));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ==========================================================
	// Bus and helper tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	function automatic logic [31:0] ew(input logic [7:0] a);
		return {24'h58A456, a};
	endfunction
	// Done is polled, never waited for by a fixed count
	task automatic run_op(input logic [2:0] op, input logic [1:0] code, input logic sh,
		output logic [31:0] st);
		int n;
		wr(`EMA_R_STATUS, 32'h2);
		wr(`EMA_R_CMD, (32'h1 << `EMA_CMD_GO) | (32'(sh) << `EMA_CMD_SHADOW) | {26'h0, code, 1'b0, op});
		n = 0;
		st = '0;
		while (st[`EMA_ST_DONE] !== 1'b1 && n < 20000) begin
			rd(`EMA_R_STATUS, st);
			n++;
		end
		`CHK(st[1:0], 2'h2)
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		wr(`EMA_R_ADDR, 32'h1F);
		rd(`EMA_R_ADDR, r);
		`CHK(r[7:0], 8'h1F)
		apb(1'b0, 8'h40, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000)
		rd(`EMA_R_CMD, r);
		`CHK(r, 32'h0)
	endtask
	task automatic t_read(input logic [7:0] a, input logic sh, input logic [31:0] x);
		logic [31:0] st, r;
		wr(`EMA_R_ADDR, {24'h0, a});
		run_op(`EMA_CMD_OP_READ, 2'h0, sh, st);
		rd(`EMA_R_RDATA, r);
		`CHK(r, x)
		`CHK(st[3], 1'b0)
		rd(`EMA_R_FLAGS, r);
		`CHK(r[`EMA_WARN_CRC], 1'b0)
	endtask
	task automatic t_write;
		logic [31:0] st;
		wr(`EMA_R_ADDR, 32'h02);
		wr(`EMA_R_WDATA, 32'h58A45678);
		run_op(`EMA_CMD_OP_WRITE, 2'h0, 1'b0, st);
		`CHK(st[4], 1'b0)
		t_read(8'h02, 1'b0, 32'h58A45678);
		run_op(`EMA_CMD_OP_WRITE, 2'h0, 1'b1, st);
		t_read(8'h02, 1'b1, 32'h58A45678);
	endtask
	task automatic t_locked;
		logic [31:0] st, r;
		wr(`EMA_R_ADDR, 32'h3F);
		run_op(`EMA_CMD_OP_WRITE, 2'h0, 1'b0, st);
		`CHK(st[4], 1'b1)
		rd(`EMA_R_FLAGS, r);
		`CHK(r[`EMA_WARN_XACC], 1'b1)
	endtask
	task automatic mchk(input logic [1:0] code, input logic [7:0] a, input logic f);
		logic [31:0] st;
		wr(`EMA_R_WDATA, ew(a));
		wr(`EMA_R_ADDR, {24'h0, a});
		run_op(`EMA_CMD_OP_READ, code, 1'b0, st);
		`CHK(st[2], f)
	endtask
	task automatic t_margin;
		logic [31:0] st, r;
		run_op(`EMA_CMD_OP_CLEAR, 2'h0, 1'b0, st);
		mchk(2'h1, 8'h05, 1'b1);
		mchk(2'h1, 8'h06, 1'b0);
		mchk(2'h2, 8'h05, 1'b0);
		rd(`EMA_R_FLAGS, r);
		`CHK(r, 32'h0)
		run_op(`EMA_CMD_OP_ACTION_CODE_FIELD, 2'h0, 1'b0, st);
		t_read(8'h05, 1'b0, ew(8'h05));
	endtask

	// ==========================================================
	// Run control
	task give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#9000000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		req = '0;
		presetn = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_read(8'h1F, 1'b0, ew(8'h1F));
		t_read(8'h1F, 1'b1, ew(8'h5F));
		t_write();
		t_locked();
		t_margin();
		give_verdict();
	end
endmodule // ema_host_tb
